// ===== hw/ddc_map.svh
// Behaviour
// - Read or write to a bank waits at least 16 ns after its activation.
// - Row stays open 36 ns minimum, closed by precharge before 70,000 ns; code forces the precharge 70,100 ns or more after activation.
// - Same-bank activations, or activation then auto refresh, spaced 52 ns minimum.
// - After auto refresh wait 60 ns before activation or another refresh.
// - Auto-precharge read or write no sooner than 16 ns after activation.
// - Activations to different banks spaced at least 8 ns.
// - After auto-precharge write, reactivation waits write recovery plus precharge, whole clocks.
// - At least 2 clocks from last write data to a read.
// - After self refresh exit, non-read commands wait at least 70 ns.
// - After self refresh exit, first read waits at least 200 clocks.
// - Auto refresh issued at average interval no longer than 7.8 us; code adds one owed refresh per 157 clk cycles (7.85 us).
// - Mode register set and any following command spaced 2 clocks minimum.
// - First write strobe latching edge 0.72 to 1.28 clocks after write.
// - Write strobe preamble may start with zero setup time.
// - Refreshes may be postponed, but never more than eight owed.
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH

// ----------------------------------------------------------------
// Clocking
// ----------------------------------------------------------------
`define DDC_CLK_NS       50
`define DDC_TCK_NS       (2 * `DDC_CLK_NS)
`define DDC_UP(ns)       (((ns) + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_DOWN(ns)     ((ns) / `DDC_CLK_NS)
`define DDC_UP_TCK(ns)   (((ns) + `DDC_TCK_NS - 1) / `DDC_TCK_NS)

// ----------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------
`define DDC_RCD_NS       16
`define DDC_RCD_CYC      `DDC_UP(`DDC_RCD_NS)
`define DDC_RAS_MIN_NS   36
`define DDC_RAS_MIN_CYC  `DDC_UP(`DDC_RAS_MIN_NS)
`define DDC_RAS_MAX_NS   70000
`define DDC_RAS_MAX_CYC  `DDC_DOWN(`DDC_RAS_MAX_NS)
`define DDC_RC_NS        52
`define DDC_RC_CYC       `DDC_UP(`DDC_RC_NS)
`define DDC_RFC_NS       60
`define DDC_RFC_CYC      `DDC_UP(`DDC_RFC_NS)
`define DDC_RRD_NS       8
`define DDC_RRD_CYC      `DDC_UP(`DDC_RRD_NS)
`define DDC_WR_NS        15
`define DDC_WR_CYC       `DDC_UP(`DDC_WR_NS)
`define DDC_RP_NS        16
`define DDC_RP_CYC       `DDC_UP(`DDC_RP_NS)
`define DDC_DAL_CYC      (2 * (`DDC_UP_TCK(`DDC_WR_NS) + `DDC_UP_TCK(`DDC_RP_NS)))
`define DDC_WTR_TCK      2
`define DDC_WRDATA_CYC   4
`define DDC_WTR_CYC      (`DDC_WRDATA_CYC + 2 * `DDC_WTR_TCK)
`define DDC_XSNR_NS      70
`define DDC_XSNR_CYC     `DDC_UP(`DDC_XSNR_NS)
`define DDC_XSRD_TCK     200
`define DDC_XSRD_CYC     (2 * `DDC_XSRD_TCK)
`define DDC_REFI_NS      7800
`define DDC_REFI_CYC     `DDC_DOWN(`DDC_REFI_NS)
`define DDC_MRD_TCK      2
`define DDC_MRD_CYC      (2 * `DDC_MRD_TCK)
`define DDC_OWED_MAX     8

// ----------------------------------------------------------------
// Command pin codes {ras_n, cas_n, we_n}
// ----------------------------------------------------------------
`define DDC_PIN_NOP      3'h7
`define DDC_PIN_ACT      3'h3
`define DDC_PIN_RD       3'h5
`define DDC_PIN_WR       3'h4
`define DDC_PIN_PRE      3'h2
`define DDC_PIN_REF      3'h1
`define DDC_PIN_MRS      3'h0

`endif

// ===== hw/ddc_pkg.sv
package ddc_pkg;

  typedef logic [10:0] ddc_ctr_t;

  typedef enum logic [2:0] {
    CMD_ACT = 3'h0,
    CMD_RD  = 3'h1,
    CMD_WR  = 3'h2,
    CMD_PRE = 3'h3,
    CMD_REF = 3'h4,
    CMD_MRS = 3'h5,
    CMD_SRE = 3'h6,
    CMD_SRX = 3'h7
  } ddc_cmd_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'h1,
    ST_SREF = 2'h2
  } ddc_state_t;

  typedef struct packed {
    ddc_cmd_t    cmd;
    logic [1:0]  bank;
    logic        autoclose;
    logic [12:0] addr;
  } ddc_req_t;

  typedef struct packed {
    logic        ck;
    logic        ck_n;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] a;
    logic        dqs_o;
    logic        dqs_oe;
  } ddc_pins_t;

endpackage

// ===== hw/ddc_host.sv
`timescale 1ns/1ps
`include "ddc_map.svh"

module ddc_host
  import ddc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  // Command request
  input  wire logic       req_valid,
  input  wire ddc_req_t   req,
  // Request answer
  output logic            done_q,
  output logic            err_q,
  output logic [3:0]      owed_q,
  // Memory pins
  output ddc_pins_t       pins_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic ddc_ctr_t dec(input ddc_ctr_t x);
    dec = (x == '0) ? '0 : x - 11'h1;
  endfunction

  function automatic ddc_ctr_t maxc(input ddc_ctr_t x, input ddc_ctr_t y);
    maxc = (x > y) ? x : y;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ddc_state_t st_q;
  logic [3:0] open_q;
  ddc_ctr_t   act_blk_q [4];
  ddc_ctr_t   rw_blk_q  [4];
  ddc_ctr_t   pre_blk_q [4];
  ddc_ctr_t   rasmax_q  [4];
  ddc_ctr_t   rrd_q, rfc_q, wtr_q, mrd_q, xsnr_q, xsrd_q, refi_q;
  logic [2:0] wseq_q;

  // ----------------------------------------------------------------
  // Issue decision
  // ----------------------------------------------------------------
  logic       slot, any_open, ref_ok, issue, illegal, from_user;
  ddc_cmd_t   icmd;
  logic [1:0] ibank;
  logic       iap;
  logic [1:0] fbank;
  logic       fpre;

  assign slot     = ce && pins_q.ck;
  assign any_open = |open_q;
  assign ref_ok   = (act_blk_q[0] == '0) && (act_blk_q[1] == '0) &&
                    (act_blk_q[2] == '0) && (act_blk_q[3] == '0) &&
                    (rfc_q == '0) && (mrd_q == '0) && (xsnr_q == '0);

  always_comb begin
    fpre  = 1'b0;
    fbank = 2'h0;
    for (int b = 3; b >= 0; b--) begin
      // Close rows held too long, or all rows when refresh debt is full
      if (open_q[b] && pre_blk_q[b] == '0 && mrd_q == '0 &&
          (rasmax_q[b] == '0 || owed_q == 4'(`DDC_OWED_MAX))) begin
        fpre  = 1'b1;
        fbank = 2'(b);
      end
    end
  end

  always_comb begin
    issue     = 1'b0;
    illegal   = 1'b0;
    from_user = 1'b0;
    icmd      = req.cmd;
    ibank     = req.bank;
    iap       = req.autoclose;
    if (!slot) begin
      issue = 1'b0;
    end else if (st_q == ST_RUN && fpre) begin
      issue = 1'b1;
      icmd  = CMD_PRE;
      ibank = fbank;
      iap   = 1'b0;
    end else if (st_q == ST_RUN && owed_q != 4'h0 && !any_open && ref_ok &&
                 (!req_valid || owed_q == 4'(`DDC_OWED_MAX))) begin
      issue = 1'b1;
      icmd  = CMD_REF;
      iap   = 1'b0;
    end else if (st_q == ST_RUN && owed_q == 4'(`DDC_OWED_MAX)) begin
      // Full debt: user waits until the forced refresh lands
      issue = 1'b0;
    end else if (req_valid && st_q == ST_SREF) begin
      illegal   = (req.cmd != CMD_SRX);
      issue     = (req.cmd == CMD_SRX);
      from_user = 1'b1;
    end else if (req_valid) begin
      from_user = 1'b1;
      case (req.cmd)
        CMD_ACT: begin
          illegal = open_q[req.bank];
          issue   = !illegal && act_blk_q[req.bank] == '0 && rrd_q == '0 &&
                    rfc_q == '0 && mrd_q == '0 && xsnr_q == '0;
        end
        CMD_RD: begin
          illegal = !open_q[req.bank];
          issue   = !illegal && rw_blk_q[req.bank] == '0 && wtr_q == '0 &&
                    xsrd_q == '0 && mrd_q == '0;
        end
        CMD_WR: begin
          illegal = !open_q[req.bank];
          issue   = !illegal && rw_blk_q[req.bank] == '0 && wseq_q == 3'h0 &&
                    xsnr_q == '0 && mrd_q == '0;
        end
        CMD_PRE: begin
          illegal = !open_q[req.bank];
          issue   = !illegal && pre_blk_q[req.bank] == '0 &&
                    xsnr_q == '0 && mrd_q == '0;
        end
        CMD_REF, CMD_SRE: begin
          illegal = any_open;
          issue   = !illegal && ref_ok;
        end
        CMD_MRS: begin
          illegal = any_open;
          issue   = !illegal && mrd_q == '0 && xsnr_q == '0;
        end
        default: begin
          illegal = 1'b1;
          issue   = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Run and self refresh mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= ST_RUN;
    end else if (ce && issue) begin
      if (icmd == CMD_SRE) begin
        st_q <= ST_SREF;
      end else if (icmd == CMD_SRX) begin
        st_q <= ST_RUN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-bank timers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      open_q <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        act_blk_q[b] <= '0;
        rw_blk_q[b]  <= '0;
        pre_blk_q[b] <= '0;
        rasmax_q[b]  <= '0;
      end
    end else if (ce) begin
      for (int b = 0; b < 4; b++) begin
        act_blk_q[b] <= dec(act_blk_q[b]);
        rw_blk_q[b]  <= dec(rw_blk_q[b]);
        pre_blk_q[b] <= dec(pre_blk_q[b]);
        rasmax_q[b]  <= dec(rasmax_q[b]);
        if (issue && ibank == 2'(b)) begin
          case (icmd)
            CMD_ACT: begin
              open_q[b]    <= 1'b1;
              rw_blk_q[b]  <= 11'(`DDC_RCD_CYC);
              pre_blk_q[b] <= 11'(`DDC_RAS_MIN_CYC);
              act_blk_q[b] <= 11'(`DDC_RC_CYC);
              rasmax_q[b]  <= 11'(`DDC_RAS_MAX_CYC);
            end
            CMD_RD: begin
              if (iap) begin
                open_q[b]    <= 1'b0;
                act_blk_q[b] <= maxc(act_blk_q[b], pre_blk_q[b] + 11'(`DDC_RP_CYC));
              end
            end
            CMD_WR: begin
              pre_blk_q[b] <= maxc(pre_blk_q[b], 11'(`DDC_WRDATA_CYC + `DDC_WR_CYC));
              if (iap) begin
                open_q[b]    <= 1'b0;
                act_blk_q[b] <= maxc(act_blk_q[b],
                                     11'(`DDC_WRDATA_CYC + `DDC_DAL_CYC));
              end
            end
            CMD_PRE: begin
              open_q[b]    <= 1'b0;
              act_blk_q[b] <= maxc(act_blk_q[b], 11'(`DDC_RP_CYC));
            end
            default: begin
              open_q[b] <= open_q[b];
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared timers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rrd_q  <= '0;
      rfc_q  <= '0;
      wtr_q  <= '0;
      mrd_q  <= '0;
      xsnr_q <= '0;
      xsrd_q <= '0;
    end else if (ce) begin
      rrd_q  <= (issue && icmd == CMD_ACT) ? 11'(`DDC_RRD_CYC) : dec(rrd_q);
      rfc_q  <= (issue && icmd == CMD_REF) ? 11'(`DDC_RFC_CYC) : dec(rfc_q);
      wtr_q  <= (issue && icmd == CMD_WR) ? 11'(`DDC_WTR_CYC) : dec(wtr_q);
      mrd_q  <= (issue && icmd == CMD_MRS) ? 11'(`DDC_MRD_CYC) : dec(mrd_q);
      xsnr_q <= (issue && icmd == CMD_SRX) ? 11'(`DDC_XSNR_CYC) : dec(xsnr_q);
      xsrd_q <= (issue && icmd == CMD_SRX) ? 11'(`DDC_XSRD_CYC) : dec(xsrd_q);
    end
  end

  // ----------------------------------------------------------------
  // Refresh debt
  // ----------------------------------------------------------------
  logic refi_tick, ref_issue;
  assign refi_tick = (st_q == ST_RUN) && (refi_q == '0);
  assign ref_issue = issue && icmd == CMD_REF;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refi_q <= 11'(`DDC_REFI_CYC);
      owed_q <= 4'h0;
    end else if (ce) begin
      // Device refreshes itself while in self refresh, so debt is dropped
      if (st_q == ST_SREF || (issue && icmd == CMD_SRE)) begin
        refi_q <= 11'(`DDC_REFI_CYC);
        owed_q <= 4'h0;
      end else begin
        refi_q <= refi_tick ? 11'(`DDC_REFI_CYC) : dec(refi_q);
        if (refi_tick && !ref_issue && owed_q != 4'(`DDC_OWED_MAX)) begin
          owed_q <= owed_q + 4'h1;
        end else if (!refi_tick && ref_issue && owed_q != 4'h0) begin
          // A user refresh with no debt must not wrap the count
          owed_q <= owed_q - 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins, strobe and answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins_q <= '{ck: 1'b0, ck_n: 1'b1, cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
                  cas_n: 1'b1, we_n: 1'b1, ba: 2'h0, a: 13'h0000,
                  dqs_o: 1'b0, dqs_oe: 1'b0};
      wseq_q <= 3'h0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (ce) begin
      pins_q.ck   <= ~pins_q.ck;
      pins_q.ck_n <= pins_q.ck;
      done_q      <= from_user && (issue || illegal);
      err_q       <= from_user && illegal;
      // Command pins change with a falling memory clock edge and hold a whole clock
      if (slot) begin
        pins_q.cs_n <= 1'b0;
        {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= `DDC_PIN_NOP;
        if (issue) begin
          pins_q.ba <= ibank;
          pins_q.a  <= req.addr;
          case (icmd)
            CMD_ACT: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= `DDC_PIN_ACT;
            CMD_RD:  {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= `DDC_PIN_RD;
            CMD_WR:  {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= `DDC_PIN_WR;
            CMD_PRE: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= `DDC_PIN_PRE;
            CMD_MRS: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= `DDC_PIN_MRS;
            CMD_SRX: pins_q.cke <= 1'b1;
            default: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= `DDC_PIN_REF;
          endcase
          if (icmd == CMD_SRE) begin
            pins_q.cke <= 1'b0;
          end
          if (icmd == CMD_RD || icmd == CMD_WR) begin
            pins_q.a[10] <= iap;
          end else if (icmd == CMD_PRE) begin
            pins_q.a[10] <= 1'b0;
          end
        end
      end
      // Strobe: half-clock low preamble, one high phase, whole-clock postamble
      wseq_q <= (issue && icmd == CMD_WR) ? 3'h1 :
                (wseq_q == 3'h5) ? 3'h0 :
                (wseq_q != 3'h0) ? wseq_q + 3'h1 : 3'h0;
      pins_q.dqs_oe <= (wseq_q >= 3'h2) && (wseq_q <= 3'h5);
      pins_q.dqs_o  <= (wseq_q == 3'h3);
    end
  end

endmodule

// ===== dv/ddc_host_props.sv
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_host_props
  import ddc_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Observed outputs
  input wire logic [3:0] owed_q,
  input wire ddc_pins_t  pins_q
);
  logic [2:0]  rcw;
  logic        live, act, rd, wr, pre, rf, same, cke_q;
  logic [1:0]  ba_q;
  logic [10:0] act_q, ref_q, mrs_q, srx_q, wr_q;
  assign rcw  = {pins_q.ras_n, pins_q.cas_n, pins_q.we_n};
  assign live = !pins_q.cs_n && !pins_q.ck && rcw != `DDC_PIN_NOP;
  assign act  = live && rcw == `DDC_PIN_ACT;
  assign rd   = live && rcw == `DDC_PIN_RD;
  assign wr   = live && rcw == `DDC_PIN_WR;
  assign pre  = live && rcw == `DDC_PIN_PRE;
  assign rf   = live && rcw == `DDC_PIN_REF;
  assign same = pins_q.ba == ba_q;
  // Ages saturate and start old, so nothing fires right after reset
  function automatic logic [10:0] age(input logic hit, input logic [10:0] v);
    return hit ? 11'h001 : v + 11'(v != 11'h7ff);
  endfunction
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {act_q, ref_q, mrs_q, srx_q, wr_q} <= '1;
      cke_q <= 1'b1;
      ba_q  <= 2'h0;
    end else begin
      act_q <= age(act, act_q);
      ref_q <= age(rf, ref_q);
      mrs_q <= age(live && rcw == `DDC_PIN_MRS, mrs_q);
      srx_q <= age(pins_q.cke && !cke_q, srx_q);
      wr_q  <= age(wr, wr_q);
      cke_q <= pins_q.cke;
      if (act) begin
        ba_q <= pins_q.ba;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_RCD: assert property ((rd || wr) && same |-> act_q >= `DDC_RCD_CYC)
    else $error("access too soon after activate");
  AST_RAS: assert property (pre && same |-> act_q >= `DDC_RAS_MIN_CYC)
    else $error("row closed too early");
  AST_RC: assert property (act && same || rf |-> act_q >= `DDC_RC_CYC)
    else $error("activate spacing too short");
  AST_RFC: assert property (act || rf |-> ref_q >= `DDC_RFC_CYC)
    else $error("command too soon after refresh");
  AST_RRD: assert property (act |-> act_q >= `DDC_RRD_CYC)
    else $error("bank to bank activate too close");
  AST_WTR: assert property (rd |-> wr_q >= `DDC_WTR_CYC)
    else $error("read too soon after write");
  AST_XSNR: assert property (live && !rd |-> srx_q >= `DDC_XSNR_CYC)
    else $error("command too soon after self refresh exit");
  AST_XSRD: assert property (rd |-> srx_q >= `DDC_XSRD_CYC)
    else $error("read too soon after self refresh exit");
  AST_MRD: assert property (live |-> mrs_q >= `DDC_MRD_CYC)
    else $error("command too soon after mode set");
  AST_DQS: assert property (wr |-> ##2 (pins_q.dqs_oe && !pins_q.dqs_o) ##1 pins_q.dqs_o)
    else $error("write strobe misplaced");
  AST_OWED: assert property (owed_q <= `DDC_OWED_MAX)
    else $error("too many refreshes owed");
endmodule

bind ddc_host ddc_host_props ddc_host_props_i (
  .clk     (clk),
  .reset_n (reset_n),
  .owed_q  (owed_q),
  .pins_q  (pins_q)
);

// ===== dv/ddc_dram_model.sv
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_dram_model
  import ddc_pkg::*;
(
  // Memory pins
  input  wire ddc_pins_t pins,
  // Findings
  output int             viol,
  output int             refs
);
  realtime    t_act [4] = '{default: -1e9};
  realtime    t_wap [4] = '{default: -1e9};
  realtime    t_any = -1e9, t_ref = -1e9, t_mrs = -1e9, t_wr = -1e9, t_srx = -1e9, now;
  logic [3:0] open_q = 4'h0;
  logic       in_sr = 1'b0;
  logic [2:0] rcw;
  assign rcw = {pins.ras_n, pins.cas_n, pins.we_n};
  initial begin
    viol = 0;
    refs = 0;
  end
  task automatic need(input bit ok);
    if (!ok) viol++;
  endtask
  always @(negedge pins.cke) in_sr = 1'b1;
  always @(posedge pins.cke) begin
    if (in_sr) begin
      in_sr = 1'b0;
      t_srx = $realtime;
    end
  end
  // Commands latch on the rising memory clock; limits kept in ns
  always @(posedge pins.ck) begin
    now = $realtime;
    if (!pins.cs_n && rcw != `DDC_PIN_NOP) begin
      need(now - t_mrs >= 200.0);
      need(now - t_srx >= (rcw == `DDC_PIN_RD ? 20000.0 : 70.0));
      case (rcw)
        `DDC_PIN_ACT: begin
          need(!open_q[pins.ba] && now - t_any >= 8.0);
          need(now - t_act[pins.ba] >= 52.0 && now - t_ref >= 60.0);
          need(now - t_wap[pins.ba] >= 400.0);
          open_q[pins.ba] = 1'b1;
          t_act[pins.ba] = now;
          t_any = now;
        end
        `DDC_PIN_RD, `DDC_PIN_WR: begin
          need(open_q[pins.ba] && now - t_act[pins.ba] >= 16.0);
          if (rcw == `DDC_PIN_RD) need(now - t_wr >= 400.0);
          else t_wr = now;
          if (rcw == `DDC_PIN_WR && pins.a[10]) t_wap[pins.ba] = now;
          if (pins.a[10]) open_q[pins.ba] = 1'b0;
        end
        `DDC_PIN_PRE: begin
          need(now - t_act[pins.ba] >= 36.0 && now - t_act[pins.ba] <= 70000.0);
          open_q[pins.ba] = 1'b0;
        end
        `DDC_PIN_REF: begin
          need(open_q == 4'h0 && now - t_ref >= 60.0);
          refs++;
          t_ref = now;
        end
        default: begin
          need(open_q == 4'h0);
          t_mrs = now;
        end
      endcase
    end
  end
endmodule

// ===== dv/tb_ddc_host.sv
`timescale 1ns/1ps
`include "ddc_map.svh"
module tb_ddc_host;
  import ddc_pkg::*;
  `define CHK(a, b) \
    begin \
      n_compared++; \
      if ((a) !== (b)) begin \
        fails++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
      end \
    end
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       ce = 1'b1;
  logic       req_valid = 1'b0;
  ddc_req_t   req = '0;
  logic       done_q, err_q;
  logic [3:0] owed_q, mx;
  ddc_pins_t  pins_q;
  int         viol, refs, gap, fails = 0, n_compared = 0;
  time        t_last = 0, t_a;
  always #25 clk = ~clk;
  ddc_host ddc_host_i (.clk(clk), .reset_n(reset_n), .ce(ce), .req_valid(req_valid),
    .req(req), .done_q(done_q), .err_q(err_q), .owed_q(owed_q), .pins_q(pins_q));
  ddc_dram_model ddc_dram_model_i (.pins(pins_q), .viol(viol), .refs(refs));
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Holds the request until answered; gap is in clk cycles
  task automatic issue(input ddc_cmd_t c, input logic [1:0] b, input logic ac, input logic e);
    int n;
    n = 0;
    @(negedge clk);
    req <= '{cmd: c, bank: b, autoclose: ac, addr: 13'h0123};
    req_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (done_q !== 1'b1 && n < 1000);
    `CHK({done_q, err_q}, {1'b1, e})
    req_valid <= 1'b0;
    gap = int'(($time - t_last) / 50);
    t_last = $time;
  endtask
  task automatic t_rw();
    issue(CMD_ACT, 2'h0, 1'b0, 1'b0);
    issue(CMD_WR, 2'h0, 1'b0, 1'b0);
    issue(CMD_RD, 2'h0, 1'b0, 1'b0);
    `CHK(gap >= `DDC_WTR_CYC, 1'b1)
    issue(CMD_ACT, 2'h0, 1'b0, 1'b1);
    issue(CMD_RD, 2'h1, 1'b0, 1'b1);
    issue(CMD_REF, 2'h0, 1'b0, 1'b1);
    issue(CMD_SRX, 2'h0, 1'b0, 1'b1);
    issue(CMD_PRE, 2'h0, 1'b0, 1'b0);
  endtask
  task automatic t_banks();
    issue(CMD_ACT, 2'h1, 1'b0, 1'b0);
    t_a = t_last;
    issue(CMD_ACT, 2'h2, 1'b0, 1'b0);
    `CHK(gap >= `DDC_RRD_CYC, 1'b1)
    issue(CMD_PRE, 2'h1, 1'b0, 1'b0);
    issue(CMD_PRE, 2'h2, 1'b0, 1'b0);
    issue(CMD_ACT, 2'h1, 1'b0, 1'b0);
    `CHK(($time - t_a) / 50 >= `DDC_RC_CYC, 1'b1)
    issue(CMD_WR, 2'h1, 1'b1, 1'b0);
    `CHK(gap >= `DDC_RCD_CYC, 1'b1)
    issue(CMD_ACT, 2'h1, 1'b0, 1'b0);
    `CHK(gap >= `DDC_WRDATA_CYC + `DDC_DAL_CYC, 1'b1)
    issue(CMD_PRE, 2'h1, 1'b0, 1'b0);
  endtask
  task automatic t_mrs();
    issue(CMD_MRS, 2'h0, 1'b0, 1'b0);
    issue(CMD_MRS, 2'h0, 1'b0, 1'b0);
    `CHK(gap >= `DDC_MRD_CYC, 1'b1)
    issue(CMD_REF, 2'h0, 1'b0, 1'b0);
    `CHK(gap >= `DDC_MRD_CYC, 1'b1)
    issue(CMD_ACT, 2'h0, 1'b0, 1'b0);
    `CHK(gap >= `DDC_RFC_CYC, 1'b1)
    issue(CMD_PRE, 2'h0, 1'b0, 1'b0);
  endtask
  task automatic t_sref();
    issue(CMD_SRE, 2'h0, 1'b0, 1'b0);
    issue(CMD_ACT, 2'h0, 1'b0, 1'b1);
    issue(CMD_SRX, 2'h0, 1'b0, 1'b0);
    t_a = t_last;
    issue(CMD_ACT, 2'h0, 1'b0, 1'b0);
    `CHK(gap >= `DDC_XSNR_CYC, 1'b1)
    issue(CMD_RD, 2'h0, 1'b0, 1'b0);
    `CHK(($time - t_a) / 50 >= `DDC_XSRD_CYC, 1'b1)
    issue(CMD_PRE, 2'h0, 1'b0, 1'b0);
  endtask
  // Clock enable low must hold every pin, memory clock and debt
  task automatic t_freeze();
    ddc_pins_t  p;
    logic [3:0] o;
    @(negedge clk);
    ce <= 1'b0;
    @(negedge clk);
    p = pins_q;
    o = owed_q;
    repeat (20) @(negedge clk);
    `CHK({pins_q, owed_q}, {p, o})
    ce <= 1'b1;
  endtask
  // Open row blocks refresh, so the debt must climb to its cap
  task automatic t_refresh();
    int n;
    mx = 4'h0;
    n = 0;
    issue(CMD_ACT, 2'h3, 1'b0, 1'b0);
    repeat (1350) begin
      @(negedge clk);
      if (owed_q > mx) mx = owed_q;
    end
    `CHK(mx, 4'(`DDC_OWED_MAX))
    while (owed_q !== 4'h0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK(owed_q, 4'h0)
    `CHK(refs > 0, 1'b1)
    issue(CMD_RD, 2'h3, 1'b0, 1'b1);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    `CHK({pins_q.cs_n, pins_q.cke, pins_q.dqs_oe, owed_q}, {3'h6, 4'h0})
    reset_n <= 1'b1;
    t_rw();
    t_freeze();
    t_banks();
    t_mrs();
    t_sref();
    t_refresh();
    `CHK(viol, 0)
    tally_and_finish();
  end
  initial begin
    #1_000_000;
    fails++;
    tally_and_finish();
  end
endmodule
